// ==== hdl/ptwb_target_window_bars.sv ====
// Base address, subsystem id and expansion ROM registers with window decode.
// Assumes straps are steady during reset, EEPROM bytes stream in with ee_wr
// and ee_done starts the unpack; config and local accesses are single-cycle strobes.
`timescale 1ns/100ps
`include "ptwb_params.svh"
// Contract
// - Image 0 enabled by strap and byte7 bit5
// - Bus-disable strap enables both images
// - Disabled image register reads zero, read-only
// - Image 1 enabled by strap and byte8 bit7
// - Compare base with AD31 down to 16+n
// - Only bits above block size writable
// - Prefetchable flag loadable, locally writable, no prefetch
// - Prefetch reads only when control enables
// - Space flag reports memory or I/O
// - Subsystem ids loaded from EEPROM, else zero
// - Local writes to ids apply; config ignored
// - ROM register enabled by byte5 bit7 only
// - ROM decode enable bit, resets zero
// - ROM writes from both buses outside load
// - ROM block-size code sets writable bits
// - Image 0 at 018, 010 with messaging
module ptwb_target_window_bars (
  input wire logic clk,
  input wire logic resetn,
  input wire logic id_load_strap_pin,
  input wire logic bus_disable_strap,
  input wire logic msg_unit_enable,
  input wire logic ee_wr,
  input wire logic [3:0] ee_addr,
  input wire logic [7:0] ee_data,
  input wire logic ee_done,
  input wire logic [3:0] img0_block_size_code,
  input wire logic [3:0] img1_block_size_code,
  input wire logic [2:0] rom_block_size_code,
  input wire logic img0_space_select_flag,
  input wire logic img1_space_select_flag,
  input wire logic img0_local_prefetch_enable,
  input wire logic img1_local_prefetch_enable,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_addr,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata,
  input wire logic lcl_wr,
  input wire logic lcl_rd,
  input wire logic [7:0] lcl_addr,
  input wire logic [31:0] lcl_wdata,
  output logic [31:0] lcl_rdata,
  input wire logic addr_phase,
  input wire logic addr_is_io,
  input wire logic [31:0] ad,
  input wire logic rd_req,
  output logic img0_hit,
  output logic img1_hit,
  output logic rom_hit,
  output logic img0_prefetch_read,
  output logic img1_prefetch_read,
  output logic loading
);
  ptwb_pkg::ptwb_state_t state_q, state_d;
  logic strap_ee_q, strap_dis_q, strap_seen_q;
  logic img0_en_q, img1_en_q, rom_en_q;
  logic [15:0] img0_ba_q, img1_ba_q, rom_ba_q;
  logic img0_prefetchable_flag_q, img1_prefetchable_flag_q, rom_dec_q;
  logic [31:0] sid_q;
  logic [3:0] ld_idx_q;
  logic [7:0] ee_rd;

  // Mask of writable/compared base bits for a block-size code
  function automatic logic [15:0] ba_mask(input logic [3:0] code);
    ba_mask = 16'hffff << code;
  endfunction : ba_mask

  function automatic logic [31:0] bar_word(input logic en, input logic [15:0] ba,
                                           input logic prefetchable_flag, input logic io);
    bar_word = en ? {ba, 12'h000, prefetchable_flag, 2'b00, io} : 32'h0000_0000;
  endfunction : bar_word

  ptwb_ee_mem u_ee (
    .clk(clk),
    .resetn(resetn),
    .wr_en(ee_wr && state_q == ptwb_pkg::PTWB_LOAD),
    .wr_addr(ee_addr),
    .wr_data(ee_data),
    .rd_addr(ld_idx_q),
    .rd_data(ee_rd)
  );

  // Load sequencer: idle catches straps, load streams bytes, run after unload
  always_comb begin
    state_d = state_q;
    case (state_q)
      ptwb_pkg::PTWB_IDLE: state_d = strap_ee_q ? ptwb_pkg::PTWB_LOAD : ptwb_pkg::PTWB_RUN;
      ptwb_pkg::PTWB_LOAD: if (ld_idx_q == `PTWB_IMG1_EE_BYTE + 4'h1) begin
        state_d = ptwb_pkg::PTWB_RUN;
      end
      default: state_d = ptwb_pkg::PTWB_RUN;
    endcase
  end
  wire in_load = state_q != ptwb_pkg::PTWB_RUN;
  wire unpack = state_q == ptwb_pkg::PTWB_LOAD && (ee_done || ld_idx_q != 4'h0);

  // Straps caught on the first clock after reset release
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      strap_seen_q <= 1'b0;
      strap_ee_q <= 1'b0;
      strap_dis_q <= 1'b0;
    end else if (!strap_seen_q) begin
      strap_seen_q <= 1'b1;
      strap_ee_q <= id_load_strap_pin;
      strap_dis_q <= bus_disable_strap;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= ptwb_pkg::PTWB_IDLE;
      ld_idx_q <= 4'h0;
    end else begin
      if (strap_seen_q) state_q <= state_d;
      if (unpack) ld_idx_q <= ld_idx_q + 4'h1;
    end
  end

  // Byte just read from the memory is for index ld_idx_q - 1
  wire [3:0] ld_byte = ld_idx_q - 4'h1;
  wire ld_valid = state_q == ptwb_pkg::PTWB_LOAD && ld_idx_q != 4'h0;

  // Write decode per source
  wire img0_off_cfg = cfg_addr == (msg_unit_enable ? `PTWB_OFF_IMG0_MSG : `PTWB_OFF_IMG0);
  wire img0_off_lcl = lcl_addr == (msg_unit_enable ? `PTWB_OFF_IMG0_MSG : `PTWB_OFF_IMG0);
  wire img0_wr_cfg = cfg_wr && img0_off_cfg && img0_en_q && !in_load;
  wire img1_wr_cfg = cfg_wr && cfg_addr == `PTWB_OFF_IMG1 && img1_en_q && !in_load;
  wire rom_wr_cfg = cfg_wr && cfg_addr == `PTWB_OFF_ROM && rom_en_q && !in_load;
  wire img0_wr_lcl = lcl_wr && img0_off_lcl && img0_en_q && !in_load;
  wire img1_wr_lcl = lcl_wr && lcl_addr == `PTWB_OFF_IMG1 && img1_en_q && !in_load;
  wire rom_wr_lcl = lcl_wr && lcl_addr == `PTWB_OFF_ROM && rom_en_q && !in_load;
  wire sid_wr_lcl = lcl_wr && lcl_addr == `PTWB_OFF_SID && !in_load;
  wire [31:0] img0_wd = img0_wr_lcl ? lcl_wdata : cfg_wdata;
  wire [31:0] img1_wd = img1_wr_lcl ? lcl_wdata : cfg_wdata;
  wire [31:0] rom_wd = rom_wr_lcl ? lcl_wdata : cfg_wdata;
  wire [15:0] img0_m = ba_mask(img0_block_size_code);
  wire [15:0] img1_m = ba_mask(img1_block_size_code);
  wire [15:0] rom_m = ba_mask({1'b0, rom_block_size_code});

  // Enables and EEPROM-loaded fields
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      img0_en_q <= 1'b0;
      img1_en_q <= 1'b0;
      rom_en_q <= 1'b0;
      sid_q <= `PTWB_SID_RESET;
      img0_prefetchable_flag_q <= 1'b0;
      img1_prefetchable_flag_q <= 1'b0;
    end else begin
      if (strap_seen_q && strap_dis_q) begin
        img0_en_q <= 1'b1;
        img1_en_q <= 1'b1;
      end
      if (ld_valid) begin
        if (ld_byte == `PTWB_IMG0_EE_BYTE) begin
          img0_en_q <= ee_rd[`PTWB_IMG0_EE_BIT] | strap_dis_q;
          img0_prefetchable_flag_q <= ee_rd[`PTWB_PREFETCHABLE_FLAG_BIT];
        end
        if (ld_byte == `PTWB_IMG1_EE_BYTE) begin
          img1_en_q <= ee_rd[`PTWB_IMG1_EE_BIT] | strap_dis_q;
          img1_prefetchable_flag_q <= ee_rd[`PTWB_PREFETCHABLE_FLAG_BIT];
        end
        if (ld_byte == `PTWB_ROM_EE_BYTE) rom_en_q <= ee_rd[`PTWB_ROM_EE_BIT];
        if (ld_byte < 4'h4) sid_q[{ld_byte[1:0], 3'b000} +: 8] <= ee_rd;
      end else begin
        if (sid_wr_lcl) sid_q <= lcl_wdata;
        if (img0_wr_lcl) img0_prefetchable_flag_q <= lcl_wdata[`PTWB_PREFETCHABLE_FLAG_BIT];
        if (img1_wr_lcl) img1_prefetchable_flag_q <= lcl_wdata[`PTWB_PREFETCHABLE_FLAG_BIT];
      end
    end
  end

  // Base fields: only bits above the block size take writes
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      img0_ba_q <= `PTWB_BA_RESET;
      img1_ba_q <= `PTWB_BA_RESET;
      rom_ba_q <= `PTWB_BA_RESET;
      rom_dec_q <= 1'b0;
    end else begin
      if (img0_wr_cfg || img0_wr_lcl) begin
        img0_ba_q <= img0_wd[31:`PTWB_BA_LSB] & img0_m;
      end
      if (img1_wr_cfg || img1_wr_lcl) begin
        img1_ba_q <= img1_wd[31:`PTWB_BA_LSB] & img1_m;
      end
      if (rom_wr_cfg || rom_wr_lcl) begin
        rom_ba_q <= rom_wd[31:`PTWB_BA_LSB] & rom_m;
        rom_dec_q <= rom_wd[`PTWB_ROM_EN_BIT];
      end
    end
  end

  // Readback words
  wire [31:0] img0_word = bar_word(img0_en_q, img0_ba_q, img0_prefetchable_flag_q,
                                   img0_space_select_flag);
  wire [31:0] img1_word = bar_word(img1_en_q, img1_ba_q, img1_prefetchable_flag_q,
                                   img1_space_select_flag);
  wire [31:0] rom_word = rom_en_q ? {rom_ba_q, 15'h0000, rom_dec_q} : 32'h0000_0000;
  wire [31:0] cfg_sel = img0_off_cfg ? img0_word :
                        cfg_addr == `PTWB_OFF_IMG1 ? img1_word :
                        cfg_addr == `PTWB_OFF_SID ? sid_q :
                        cfg_addr == `PTWB_OFF_ROM ? rom_word : 32'h0000_0000;
  wire [31:0] lcl_sel = img0_off_lcl ? img0_word :
                        lcl_addr == `PTWB_OFF_IMG1 ? img1_word :
                        lcl_addr == `PTWB_OFF_SID ? sid_q :
                        lcl_addr == `PTWB_OFF_ROM ? rom_word : 32'h0000_0000;

  // Address compare; host sizing with all ones relies on masked storage
  wire img0_cmp = ((ad[31:16] ^ img0_ba_q) & img0_m) == 16'h0000;
  wire img1_cmp = ((ad[31:16] ^ img1_ba_q) & img1_m) == 16'h0000;
  wire rom_cmp = ((ad[31:16] ^ rom_ba_q) & rom_m) == 16'h0000;
  wire img0_claim = addr_phase && img0_en_q && addr_is_io == img0_space_select_flag &&
                    img0_cmp;
  wire img1_claim = addr_phase && img1_en_q && addr_is_io == img1_space_select_flag &&
                    img1_cmp;
  wire rom_claim = addr_phase && rom_en_q && rom_dec_q && !addr_is_io && rom_cmp;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cfg_rdata <= 32'h0000_0000;
      lcl_rdata <= 32'h0000_0000;
      img0_hit <= 1'b0;
      img1_hit <= 1'b0;
      rom_hit <= 1'b0;
      img0_prefetch_read <= 1'b0;
      img1_prefetch_read <= 1'b0;
      loading <= 1'b1;
    end else begin
      if (cfg_rd) cfg_rdata <= cfg_sel;
      if (lcl_rd) lcl_rdata <= lcl_sel;
      img0_hit <= img0_claim;
      img1_hit <= img1_claim;
      rom_hit <= rom_claim;
      img0_prefetch_read <= img0_claim && rd_req && img0_local_prefetch_enable;
      img1_prefetch_read <= img1_claim && rd_req && img1_local_prefetch_enable;
      loading <= !strap_seen_q || state_d != ptwb_pkg::PTWB_RUN;
    end
  end
endmodule : ptwb_target_window_bars

// ==== hdl/ptwb_params.svh ====
// Offsets, field positions and reset values of the target window register bank.
// Included by the package users; holds definitions only.
`ifndef PTWB_PARAMS_SVH
`define PTWB_PARAMS_SVH
`define PTWB_OFF_IMG0 8'h18
`define PTWB_OFF_IMG0_MSG 8'h10
`define PTWB_OFF_IMG1 8'h1c
`define PTWB_OFF_SID 8'h2c
`define PTWB_OFF_ROM 8'h30
`define PTWB_BA_LSB 16
`define PTWB_PREFETCHABLE_FLAG_BIT 3
`define PTWB_SPACE_BIT 0
`define PTWB_ROM_EN_BIT 0
`define PTWB_IMG0_EE_BYTE 4'h7
`define PTWB_IMG0_EE_BIT 5
`define PTWB_IMG1_EE_BYTE 4'h8
`define PTWB_IMG1_EE_BIT 7
`define PTWB_ROM_EE_BYTE 4'h5
`define PTWB_ROM_EE_BIT 7
`define PTWB_SID_EE_BYTE0 4'h0
`define PTWB_BA_RESET 16'h0000
`define PTWB_SID_RESET 32'h0000_0000
`define PTWB_EE_BYTES 16
`endif

// ==== hdl/ptwb_pkg.sv ====
// Types shared by the target window register bank.
// Assumes ptwb_params.svh supplies all numeric constants.
package ptwb_pkg;
  typedef enum logic [1:0] {
    PTWB_IDLE = 2'b00,
    PTWB_LOAD = 2'b01,
    PTWB_RUN = 2'b11
  } ptwb_state_t;
  typedef enum logic [1:0] {
    PTWB_SRC_NONE = 2'b00,
    PTWB_SRC_CFG = 2'b01,
    PTWB_SRC_LOCAL = 2'b10
  } ptwb_src_t;
endpackage : ptwb_pkg

// ==== hdl/ptwb_ee_mem.sv ====
// Small memory holding the serial EEPROM bytes captured during the load.
// Assumes the loader delivers one byte per write strobe; read data registered.
`timescale 1ns/100ps
`include "ptwb_params.svh"
module ptwb_ee_mem (
  input wire logic clk,
  input wire logic resetn,
  input wire logic wr_en,
  input wire logic [3:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic [3:0] rd_addr,
  output logic [7:0] rd_data
);
  logic [7:0] mem_q [`PTWB_EE_BYTES];
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem_q[wr_addr] <= wr_data;
    end
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rd_data <= 8'h00;
    end else begin
      rd_data <= mem_q[rd_addr];
    end
  end
endmodule : ptwb_ee_mem

// ==== tb/ptwb_props.sv ====
// Port checker for the target window register bank.
// Bound onto every bank instance; one clock domain.
`timescale 1ns/100ps
module ptwb_props (
  input wire logic clk,
  input wire logic resetn,
  input wire logic addr_phase,
  input wire logic addr_is_io,
  input wire logic rd_req,
  input wire logic img0_space_select_flag,
  input wire logic img1_space_select_flag,
  input wire logic img0_local_prefetch_enable,
  input wire logic img1_local_prefetch_enable,
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_addr,
  input wire logic [31:0] cfg_rdata,
  input wire logic img0_hit,
  input wire logic img1_hit,
  input wire logic rom_hit,
  input wire logic img0_prefetch_read,
  input wire logic img1_prefetch_read
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence hole_s; cfg_rd && cfg_addr == 8'h04; endsequence
  img0_claim_a: assert property (img0_hit |-> $past(addr_phase && addr_is_io == img0_space_select_flag))
    else $error("image 0 hit without matching phase");
  img1_claim_a: assert property (img1_hit |-> $past(addr_phase && addr_is_io == img1_space_select_flag))
    else $error("image 1 hit without matching phase");
  rom_mem_a: assert property (rom_hit |-> $past(addr_phase && !addr_is_io))
    else $error("rom hit without memory phase");
  pref0_gate_a: assert property (img0_prefetch_read |->
    $past(addr_phase && rd_req && img0_local_prefetch_enable))
    else $error("image 0 prefetch without enable");
  pref1_gate_a: assert property (img1_prefetch_read |->
    $past(addr_phase && rd_req && img1_local_prefetch_enable))
    else $error("image 1 prefetch without enable");
  pref0_hit_a: assert property (img0_prefetch_read |-> img0_hit)
    else $error("image 0 prefetch without hit");
  pref1_hit_a: assert property (img1_prefetch_read |-> img1_hit)
    else $error("image 1 prefetch without hit");
  hole_zero_a: assert property (hole_s |=> cfg_rdata == 32'h0000_0000)
    else $error("unmapped read not zero");
endmodule : ptwb_props
bind ptwb_target_window_bars ptwb_props ptwb_props_i (.*);

// ==== tb/ptwb_ee_model.sv ====
// Serial EEPROM stand-in streaming 16 bytes after go rises.
// Assumes the bank is in its load phase when go is raised.
`timescale 1ns/100ps
module ptwb_ee_model (
  input wire logic clk,
  input wire logic go,
  input wire logic [127:0] image,
  output logic ee_wr,
  output logic [3:0] ee_addr,
  output logic [7:0] ee_data,
  output logic ee_done
);
  initial begin
    {ee_wr, ee_addr, ee_data, ee_done} = '0;
    forever begin
      @(posedge go);
      for (int i = 0; i < 16; i++) begin
        @(negedge clk);
        ee_wr = 1'b1;
        ee_addr = i[3:0];
        ee_data = image[8*i +: 8];
      end
      @(negedge clk);
      ee_wr = 1'b0;
      ee_data = ~ee_data;
      ee_done = 1'b1;
      @(negedge clk);
      ee_done = 1'b0;
    end
  end
endmodule : ptwb_ee_model

// ==== tb/tb_top.sv ====
// Self-checking bench for the target window register bank.
// Drives at falling edges; a monitor pops expectations one cycle later.
`timescale 1ns/100ps
module tb_top;
  logic clk = 1'b0, resetn = 1'b0, go = 1'b0, pend_rd, pend_src, pend_hit;
  logic id_load_strap_pin, bus_disable_strap, msg_unit_enable, ee_wr, ee_done, loading;
  logic cfg_wr, cfg_rd, lcl_wr, lcl_rd, addr_phase, addr_is_io, rd_req, rom_hit;
  logic img0_space_select_flag, img1_space_select_flag, img0_hit, img1_hit;
  logic img0_local_prefetch_enable, img1_local_prefetch_enable;
  logic img0_prefetch_read, img1_prefetch_read;
  logic [3:0] ee_addr, img0_block_size_code, img1_block_size_code;
  logic [2:0] rom_block_size_code;
  logic [7:0] ee_data, cfg_addr, lcl_addr;
  logic [15:0] base;
  logic [31:0] cfg_wdata, cfg_rdata, lcl_wdata, lcl_rdata, ad, subsystem_identifier;
  logic [31:0] exp_q[$];
  logic [127:0] image;
  int error_cnt = 0, compares = 0;
  ptwb_target_window_bars ptwb_target_window_bars_i (.*);
  ptwb_ee_model ptwb_ee_model_i (.*);
  initial forever #2 clk = ~clk;
  task automatic chk(input string n, input logic [31:0] s, e);
    compares++;
    if (s !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  always @(posedge clk) begin
    pend_rd <= cfg_rd | lcl_rd;
    pend_src <= lcl_rd;
    pend_hit <= addr_phase;
  end
  always @(negedge clk) begin
    if (pend_rd) chk("rdata", pend_src ? lcl_rdata : cfg_rdata, exp_q.pop_front());
    if (pend_hit) chk("hits", {27'h000_0000, img0_prefetch_read, img1_prefetch_read,
      img0_hit, img1_hit, rom_hit}, exp_q.pop_front());
  end
  task automatic end_sim;
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_sim
  task automatic acc(input bit w, l, input logic [7:0] a, input logic [31:0] d);
    @(negedge clk);
    {lcl_wr, cfg_wr, lcl_rd, cfg_rd} = w ? {l, !l, 2'b00} : {2'b00, l, !l};
    {lcl_addr, cfg_addr, lcl_wdata, cfg_wdata} = {a, a, d, d};
    if (!w) exp_q.push_back(d);
    @(negedge clk);
    {lcl_wr, cfg_wr, lcl_rd, cfg_rd} = 4'h0;
  endtask : acc
  task automatic ap(input logic io, r, input logic [31:0] a, input logic [4:0] e);
    @(negedge clk);
    {addr_phase, addr_is_io, rd_req, ad} = {1'b1, io, r, a};
    exp_q.push_back({27'h000_0000, e});
    @(negedge clk);
    addr_phase = 1'b0;
  endtask : ap
  task automatic rst(input logic s, d);
    int i;
    @(negedge clk);
    {resetn, id_load_strap_pin, bus_disable_strap} = {1'b0, s, d};
    repeat (8) @(negedge clk);
    resetn = 1'b1;
    repeat (2) @(negedge clk);
    go = s;
    @(negedge clk);
    go = 1'b0;
    for (i = 0; i < 100 && loading !== 1'b0; i++) @(negedge clk);
    if (loading !== 1'b0) begin
      error_cnt++;
      end_sim();
    end
  endtask : rst
  initial begin
    {id_load_strap_pin, bus_disable_strap, msg_unit_enable, cfg_wr, cfg_rd, lcl_wr} = '0;
    {lcl_rd, addr_phase, addr_is_io, rd_req, ad, cfg_addr, lcl_addr, cfg_wdata, lcl_wdata} = '0;
    {img0_block_size_code, img1_block_size_code, rom_block_size_code} = '0;
    {img0_space_select_flag, img1_space_select_flag} = '0;
    {img0_local_prefetch_enable, img1_local_prefetch_enable} = '0;
    subsystem_identifier = $urandom(32'hb4c35440);
    base = 16'($urandom) | 16'h8001;
    image = {56'h0, 8'h88, 8'h20, 8'h00, 8'h80, 8'h00, subsystem_identifier};
    rst(1'b1, 1'b0);
    acc(0, 0, 8'h2c, subsystem_identifier);
    acc(1, 0, 8'h2c, ~subsystem_identifier);
    acc(0, 1, 8'h2c, subsystem_identifier);
    acc(1, 1, 8'h2c, ~subsystem_identifier);
    acc(0, 0, 8'h2c, ~subsystem_identifier);
    acc(0, 0, 8'h04, 32'h0000_0000);
    $display("test ids done");
    for (int n = 0; n < 16; n++) begin
      img1_block_size_code = n[3:0];
      img1_space_select_flag = n[0];
      acc(1, 0, 8'h1c, 32'hffff_ffff);
      acc(0, 0, 8'h1c, {16'hffff << n, 12'h000, 1'b1, 2'b00, n[0]});
    end
    for (int n = 0; n < 8; n++) begin
      rom_block_size_code = n[2:0];
      acc(1, n[0], 8'h30, 32'hffff_ffff);
      acc(0, 0, 8'h30, {16'hffff << n, 16'h0001});
    end
    $display("test sizing done");
    {img1_space_select_flag, img1_block_size_code, rom_block_size_code} = {1'b0, 4'h4, 3'h0};
    img1_local_prefetch_enable = 1'b1;
    acc(1, 0, 8'h1c, {base, 16'h0000});
    acc(1, 1, 8'h30, {~base, 16'h0001});
    ap(0, 1, {base[15:4], ~base[3:0], 16'h0000}, 5'h0a);
    ap(0, 1, {~base[15], base[14:0], 16'h0000}, 5'h00);
    ap(1, 1, {base, 16'h0000}, 5'h00);
    ap(0, 0, {~base, 16'h0000}, 5'h01);
    ap(1, 0, {~base, 16'h0000}, 5'h00);
    img1_local_prefetch_enable = 1'b0;
    ap(0, 1, {base, 16'h0000}, 5'h02);
    acc(1, 0, 8'h30, {~base, 16'h0000});
    ap(0, 0, {~base, 16'h0000}, 5'h00);
    $display("test decode done");
    rst(1'b0, 1'b0);
    foreach (image[i]) if (i < 4) begin
      acc(1, i != 2, 8'h1c + 8'(i * 4) + (i > 1 ? 8'h08 : 8'h00), 32'hffff_ffff);
      acc(0, 0, 8'h1c + 8'(i * 4) + (i > 1 ? 8'h08 : 8'h00), 32'h0000_0000);
    end
    $display("test disabled done");
    rst(1'b0, 1'b1);
    {msg_unit_enable, img0_local_prefetch_enable} = 2'b11;
    acc(1, 0, 8'h10, 32'hffff_ffff);
    acc(0, 0, 8'h10, 32'hffff_0000);
    acc(0, 0, 8'h30, 32'h0000_0000);
    ap(0, 1, 32'hffff_0000, 5'h14);
    $display("test strap done");
    end_sim();
  end
endmodule : tb_top
